// file: hdl/acl_params.svh
// Constants of the ancillary packet classifier: offsets, fields, resets, codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ACL_CLK_HZ        50000000
`define ACL_BUCKET_BITS   16384
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACL_OFF_CTRL      12'h000
`define ACL_OFF_RATE      12'h004
`define ACL_OFF_LANG      12'h008
`define ACL_OFF_PAGE      12'h00C
`define ACL_OFF_PAIR0     12'h010
`define ACL_OFF_PAIR3     12'h01C
`define ACL_OFF_STAT      12'h020
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define ACL_CTRL_CAP_EN   0
`define ACL_CTRL_FMT_EN   1
`define ACL_CTRL_TRIG_EN  2
`define ACL_CTRL_HDR_EN   3
`define ACL_CTRL_GEN_EN   4
`define ACL_CTRL_CAP_SRC  5
`define ACL_CTRL_FILT     7:6
`define ACL_CTRL_FSRC     9:8
`define ACL_CTRL_FVAL     13:10
`define ACL_CTRL_OFFS     19:16
`define ACL_CTRL_MASK     32'h000F3FFF
`define ACL_PAIR_EN       31
`define ACL_PAIR_MASK     32'h83FF03FF
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACL_CTRL_RESET    32'h00000000
`define ACL_RATE_RESET    32'h00000000
`define ACL_LANG_RESET    24'h656E67
`define ACL_PAGE_RESET    12'h321
`define ACL_PAIR_RESET    32'h02000200
// ----------------------------------------------------------------------
// Packet identifiers and lines
// ----------------------------------------------------------------------
`define ACL_DID_CAP       10'h161
`define ACL_SDID_708      10'h101
`define ACL_SDID_608      10'h102
`define ACL_DID_TTX       10'h143
`define ACL_SDID_TTX      10'h102
`define ACL_DID_2016      10'h241
`define ACL_SDID_FMT      10'h205
`define ACL_SDID_TRIG     10'h107
`define ACL_SDID_HDR      10'h20C
`define ACL_LINE_CAP      11'h015
`define ACL_LINE_WSS_NTSC 11'h014
`define ACL_LINE_WSS_PAL  11'h017
`define ACL_OFFS_MIN      4'hB
`define ACL_OFFS_MAX      4'h5
`endif

// file: hdl/acl_pkg.sv
// Types and shared decode functions of the ancillary packet classifier.
// Assumes the constants header is on the include path.
`include "acl_params.svh"
package acl_pkg;
  typedef struct packed {
    logic [9:0]  did;
    logic [9:0]  sdid;
    logic        hanc;
    logic [15:0] bits;
    logic [7:0]  udw0;
  } acl_pkt_type;
  typedef struct packed {
    logic [10:0] line;
    logic        field;
    logic [15:0] data;
  } acl_vbi_type;
  typedef enum logic [2:0] {
    ACL_DEST_DROP = 3'h0, ACL_DEST_CAP708 = 3'h1, ACL_DEST_CAP608 = 3'h2,
    ACL_DEST_TTX = 3'h3, ACL_DEST_TRIG = 3'h4, ACL_DEST_SEI = 3'h5, ACL_DEST_GEN = 3'h6
  } acl_dest_type;
  typedef enum logic [1:0] {
    ACL_FILT_BOTH = 2'h0, ACL_FILT_708 = 2'h1, ACL_FILT_608 = 2'h2, ACL_FILT_TTX = 2'h3
  } acl_filt_type;
  typedef enum logic [1:0] {
    ACL_FSRC_VANC = 2'h0, ACL_FSRC_WSS = 2'h1, ACL_FSRC_MANUAL = 2'h2
  } acl_fsrc_type;
  typedef struct packed {
    acl_dest_type dest;
    logic [9:0]   did;
    logic [9:0]   sdid;
    logic [3:0]   frame_offset;
  } acl_route_type;

  // Widen an 8-bit identifier; 10-bit entries pass unchanged
  function automatic logic [9:0] acl_expand_id(input logic [9:0] v);
    if (v[9:8] != 2'h0)
      return v;
    return {~(^v[7:0]), ^v[7:0], v[7:0]};
  endfunction : acl_expand_id

  function automatic logic acl_reserved(input logic [9:0] did, input logic [9:0] sdid);
    return (did == `ACL_DID_CAP && (sdid == `ACL_SDID_708 || sdid == `ACL_SDID_608)) ||
           (did == `ACL_DID_TTX && sdid == `ACL_SDID_TTX) ||
           (did == `ACL_DID_2016 && (sdid == `ACL_SDID_FMT || sdid == `ACL_SDID_TRIG ||
                                     sdid == `ACL_SDID_HDR));
  endfunction : acl_reserved
endpackage : acl_pkg

// file: hdl/acl_rate_budget.sv
// Token bucket that polices the generic transport bit rate.
// Assumes one request per cycle at most; a zero rate disables policing.
`timescale 1ns/1ps
`include "acl_params.svh"
module acl_rate_budget
  import acl_pkg::*;
(
  input  wire logic        ref_clk,    // System clock
  input  wire logic        rstn,       // Asynchronous reset, active low
  input  wire logic [31:0] rate_bps,   // Reserved rate in bits per second
  input  wire logic        spend,      // Packet asks to be sent
  input  wire logic [15:0] spend_bits, // Packet size in bits
  output logic             grant       // Packet may be sent
);
  // Credit is kept in bit-cycles so no division is needed
  localparam logic [47:0] HZ  = 48'(`ACL_CLK_HZ);
  localparam logic [47:0] CAP = 48'(`ACL_BUCKET_BITS) * HZ;

  logic [47:0] credit_r;
  logic [47:0] credit_nxt;
  logic [47:0] cost;
  logic [47:0] spent;
  logic [47:0] filled;

  assign cost   = 48'(spend_bits) * HZ;
  assign grant  = (rate_bps == 32'h0) || (credit_r >= cost);           // [R18]
  assign spent  = (spend && grant && rate_bps != 32'h0) ? credit_r - cost : credit_r;
  assign filled = spent + 48'(rate_bps);
  assign credit_nxt = (filled > CAP) ? CAP : filled;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      credit_r <= 48'h0;
    else
      credit_r <= credit_nxt;
  end
endmodule : acl_rate_budget

// file: hdl/acl_classifier.sv
// Ancillary packet classifier with its APB register file.
// Assumes packet, line and format inputs come from logic on ref_clk.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "acl_params.svh"
// Notes on behaviour
// R1: caption enable inserts 608 and 708 captions
// R2: ANC caption source autodetects 608 or 708
// R3: line-21 source on SD; otherwise ANC packets
// R4: 708 is 161/101, 608 is 161/102
// R5: both filter passes each; duplicates allowed
// R6: 708-only filter drops 608 packets
// R7: 608-only filter drops 708 packets
// R8: teletext filter passes only 143/102
// R9: language and page exported; payload untouched
// R10: WSS descriptor from line 20/23 on SD
// R11: VANC source takes descriptor from packets
// R12: manual source inserts fixed code each frame
// R13: manual code is one of eight values
// R14: descriptor output only while enabled
// R15: enabled triggers routed to SCTE 35 path
// R16: enabled HDR packets routed to SEI path
// R17: generic transport takes VANC and HANC matches
// R18: bit-rate budget may drop; zero accepted
// R19: frame offset kept within minus five to five
// R20: four match pairs, each with own enable
// R21: 8-bit entries widen to 10 bits
// R22: reserved pairs never reach generic transport
// R23: bit 8 even parity, bit 9 inverse
module acl_classifier
  import acl_pkg::*;
(
  input  wire logic          ref_clk,         // System clock, 50 MHz
  input  wire logic          rstn,            // Asynchronous reset, active low
  input  wire logic          psel,            // APB select
  input  wire logic          penable,         // APB access phase
  input  wire logic          pwrite,          // APB write
  input  wire logic [11:0]   paddr,           // APB byte address
  input  wire logic [31:0]   pwdata,          // APB write data
  output logic      [31:0]   prdata,          // APB read data
  output logic               pready,          // APB ready
  output logic               pslverr,         // APB error on unmapped address
  input  wire logic          is_sd,           // Input is standard definition
  input  wire logic          is_pal,          // SD input is 625-line
  input  wire logic          frame_start,     // One pulse per frame
  input  wire logic          pkt_valid,       // Packet header valid
  input  wire acl_pkg::acl_pkt_type pkt,      // Packet header
  input  wire logic          vbi_valid,       // VBI line word valid
  input  wire acl_pkg::acl_vbi_type vbi,      // VBI line word
  output logic               route_valid,     // Routing decision pulse
  output acl_pkg::acl_route_type route,       // Routing decision
  output logic               cap_line_valid,  // Line-21 caption word pulse
  output acl_pkg::acl_vbi_type cap_line,      // Line-21 caption word
  output logic               fmt_valid,       // Format descriptor pulse
  output logic      [3:0]    fmt_value,       // Format descriptor code
  output logic      [23:0]   teletext_caption_language, // Three letters
  output logic      [11:0]   teletext_caption_page      // Page number
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic fmt_legal(input logic [3:0] c);
    return c == 4'h0 || c == 4'h2 || c == 4'h3 || c == 4'h4 ||
           c == 4'h8 || c == 4'h9 || c == 4'hA || c == 4'hB;
  endfunction : fmt_legal

  function automatic logic [3:0] offs_clamp(input logic [3:0] o);
    if ($signed(o) < $signed(`ACL_OFFS_MIN))
      return `ACL_OFFS_MIN;
    if ($signed(o) > $signed(`ACL_OFFS_MAX))
      return `ACL_OFFS_MAX;
    return o;
  endfunction : offs_clamp

  // WSS aspect group to descriptor; unknown groups give full frame
  function automatic logic [3:0] wss_to_fmt(input logic [3:0] w);
    case (w)
      4'h8:    return 4'h9;
      4'h1:    return 4'hB;
      4'h2:    return 4'h3;
      4'hB:    return 4'h4;
      4'h4:    return 4'h4;
      4'h7:    return 4'h2;
      default: return 4'h8;
    endcase
  endfunction : wss_to_fmt

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] rate_r;
  logic [23:0] lang_r;
  logic [11:0] page_r;
  logic [31:0] pair_r [0:3];
  logic [15:0] rx_cnt_r;
  logic [15:0] drop_cnt_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_data;
  logic        addr_ok;

  wire         setup     = psel && !penable;
  wire         wr_access = psel && penable && pready_r && pwrite;
  wire         pair_sel  = paddr >= `ACL_OFF_PAIR0 && paddr <= `ACL_OFF_PAIR3 &&
                           paddr[1:0] == 2'h0;
  wire [1:0]   pair_idx  = 2'(paddr[3:2]);
  wire [31:0]  ctrl_wr   = pwdata & `ACL_CTRL_MASK;
  wire [3:0]   fval_wr   = fmt_legal(ctrl_wr[`ACL_CTRL_FVAL]) ?
                           ctrl_wr[`ACL_CTRL_FVAL] : ctrl_r[`ACL_CTRL_FVAL];     // [R13]
  wire [31:0]  ctrl_nxt  = {ctrl_wr[31:20], offs_clamp(ctrl_wr[`ACL_CTRL_OFFS]),
                            ctrl_wr[15:14], fval_wr, ctrl_wr[9:0]};              // [R19]
  wire [31:0]  pair_nxt  = {pwdata[`ACL_PAIR_EN], 5'h0, acl_expand_id(pwdata[25:16]),
                            6'h0, acl_expand_id(pwdata[9:0])};            // [R21] [R23]

  always_comb begin
    rd_data = 32'h0;
    addr_ok = 1'b1;
    if (paddr == `ACL_OFF_CTRL)
      rd_data = ctrl_r;
    else if (paddr == `ACL_OFF_RATE)
      rd_data = rate_r;
    else if (paddr == `ACL_OFF_LANG)
      rd_data = {8'h0, lang_r};
    else if (paddr == `ACL_OFF_PAGE)
      rd_data = {20'h0, page_r};
    else if (pair_sel)
      rd_data = pair_r[pair_idx];
    else if (paddr == `ACL_OFF_STAT)
      rd_data = {drop_cnt_r, rx_cnt_r};
    else
      addr_ok = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !addr_ok;
      prdata_r  <= (setup && !pwrite) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `ACL_CTRL_RESET;
      rate_r <= `ACL_RATE_RESET;
      lang_r <= `ACL_LANG_RESET;
      page_r <= `ACL_PAGE_RESET;
      for (int i = 0; i < 4; i++)
        pair_r[i] <= `ACL_PAIR_RESET;
    end else if (wr_access) begin
      if (paddr == `ACL_OFF_CTRL)
        ctrl_r <= ctrl_nxt;
      else if (paddr == `ACL_OFF_RATE)
        rate_r <= pwdata;
      else if (paddr == `ACL_OFF_LANG)
        lang_r <= pwdata[23:0];
      else if (paddr == `ACL_OFF_PAGE)
        page_r <= pwdata[11:0];
      else if (pair_sel)
        pair_r[pair_idx] <= pair_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Packet decode
  // ----------------------------------------------------------------------
  wire           cap_en   = ctrl_r[`ACL_CTRL_CAP_EN];
  wire           fmt_en   = ctrl_r[`ACL_CTRL_FMT_EN];
  wire           trig_en  = ctrl_r[`ACL_CTRL_TRIG_EN];
  wire           hdr_en   = ctrl_r[`ACL_CTRL_HDR_EN];
  wire           gen_en   = ctrl_r[`ACL_CTRL_GEN_EN];
  wire acl_filt_type filt = acl_filt_type'(ctrl_r[`ACL_CTRL_FILT]);
  wire acl_fsrc_type fsrc = acl_fsrc_type'(ctrl_r[`ACL_CTRL_FSRC]);
  wire [3:0]     fval     = ctrl_r[`ACL_CTRL_FVAL];

  wire is708     = pkt.did == `ACL_DID_CAP && pkt.sdid == `ACL_SDID_708;      // [R4]
  wire is608     = pkt.did == `ACL_DID_CAP && pkt.sdid == `ACL_SDID_608;      // [R4]
  wire is_ttx    = pkt.did == `ACL_DID_TTX && pkt.sdid == `ACL_SDID_TTX;
  wire is_fmt    = pkt.did == `ACL_DID_2016 && pkt.sdid == `ACL_SDID_FMT;
  wire is_trig   = pkt.did == `ACL_DID_2016 && pkt.sdid == `ACL_SDID_TRIG;
  wire is_hdr    = pkt.did == `ACL_DID_2016 && pkt.sdid == `ACL_SDID_HDR;
  wire use_line  = ctrl_r[`ACL_CTRL_CAP_SRC] && is_sd;                        // [R3]
  wire anc_cap   = cap_en && !use_line;                                       // [R2]
  wire take708   = anc_cap && (filt == ACL_FILT_BOTH || filt == ACL_FILT_708); // [R5] [R6]
  wire take608   = anc_cap && (filt == ACL_FILT_BOTH || filt == ACL_FILT_608); // [R5] [R7]
  wire take_ttx  = cap_en && filt == ACL_FILT_TTX;                            // [R8]

  logic [3:0] pair_hit;
  always_comb begin
    for (int i = 0; i < 4; i++)
      pair_hit[i] = pair_r[i][`ACL_PAIR_EN] && pair_r[i][9:0] == pkt.did &&
                    pair_r[i][25:16] == pkt.sdid;                             // [R20]
  end

  // HANC and VANC packets are treated alike for generic matches
  wire gen_cand  = gen_en && (|pair_hit) && !acl_reserved(pkt.did, pkt.sdid); // [R17] [R22]
  wire gen_grant;

  acl_rate_budget u_budget (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .rate_bps   (rate_r),
    .spend      (pkt_valid && gen_cand),
    .spend_bits (pkt.bits),
    .grant      (gen_grant)
  );

  // Captions go to the ES unmodified, teletext page included
  wire acl_dest_type dest_nxt =
      (is708 && take708)                ? ACL_DEST_CAP708 :                   // [R1]
      (is608 && take608)                ? ACL_DEST_CAP608 :                   // [R1]
      (is_ttx && take_ttx)              ? ACL_DEST_TTX    :                   // [R9]
      (is_trig && trig_en)              ? ACL_DEST_TRIG   :                   // [R15]
      (is_hdr && hdr_en)                ? ACL_DEST_SEI    :                   // [R16]
      (gen_cand && gen_grant)           ? ACL_DEST_GEN    :                   // [R18]
                                          ACL_DEST_DROP;
  wire [3:0] offs_nxt = (dest_nxt == ACL_DEST_GEN) ? ctrl_r[`ACL_CTRL_OFFS] : 4'h0; // [R19]

  // ----------------------------------------------------------------------
  // Format descriptor selection
  // ----------------------------------------------------------------------
  wire       use_wss  = fsrc == ACL_FSRC_WSS && is_sd;                        // [R10]
  wire [10:0] wss_ln  = is_pal ? `ACL_LINE_WSS_PAL : `ACL_LINE_WSS_NTSC;
  wire       fmt_man  = fmt_en && fsrc == ACL_FSRC_MANUAL && frame_start;     // [R12]
  wire       fmt_wss  = fmt_en && use_wss && vbi_valid && vbi.line == wss_ln; // [R10]
  wire       fmt_vanc = fmt_en && fsrc != ACL_FSRC_MANUAL && !use_wss &&
                        pkt_valid && is_fmt;                                  // [R11]
  wire [3:0] fmt_nxt  = fmt_man ? fval :
                        fmt_wss ? wss_to_fmt(vbi.data[3:0]) : pkt.udw0[6:3];
  wire       line_cap = cap_en && use_line && vbi_valid && vbi.line == `ACL_LINE_CAP; // [R3]

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      route_valid    <= 1'b0;
      route          <= '0;
      cap_line_valid <= 1'b0;
      cap_line       <= '0;
      fmt_valid      <= 1'b0;
      fmt_value      <= 4'h0;
    end else begin
      route_valid    <= pkt_valid;
      route          <= pkt_valid ? {dest_nxt, pkt.did, pkt.sdid, offs_nxt} : route;
      cap_line_valid <= line_cap;
      cap_line       <= line_cap ? vbi : cap_line;
      fmt_valid      <= fmt_man || fmt_wss || fmt_vanc;                       // [R14]
      fmt_value      <= (fmt_man || fmt_wss || fmt_vanc) ? fmt_nxt : fmt_value;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_cnt_r   <= 16'h0;
      drop_cnt_r <= 16'h0;
    end else begin
      rx_cnt_r   <= rx_cnt_r + 16'(pkt_valid);
      drop_cnt_r <= drop_cnt_r + 16'(pkt_valid && gen_cand && !gen_grant);  // [R18]
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      teletext_caption_language <= `ACL_LANG_RESET;
      teletext_caption_page     <= `ACL_PAGE_RESET;
    end else begin
      teletext_caption_language <= lang_r;                                    // [R9]
      teletext_caption_page     <= page_r;                                    // [R9]
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_cap_pkt(logic hit, acl_filt_type f);
    pkt_valid && hit && cap_en && !use_line && filt == f;
  endsequence
  sequence s_pair_write;
    wr_access && pair_sel && pwdata[9:8] == 2'h0;
  endsequence

  property p_no_reserved_gen;
    @(posedge ref_clk) disable iff (!rstn)
      route_valid && route.dest == ACL_DEST_GEN |-> !acl_reserved(route.did, route.sdid);
  endproperty
  a_no_reserved_gen: assert property (p_no_reserved_gen) // [R22]
    else $error("reserved pair routed to generic transport");
  property p_708_only;
    @(posedge ref_clk) disable iff (!rstn)
      s_cap_pkt(is608, ACL_FILT_708) |=> route_valid && route.dest == ACL_DEST_DROP;
  endproperty
  a_708_only: assert property (p_708_only) // [R6]
    else $error("608 packet passed 708-only filter");
  property p_608_only;
    @(posedge ref_clk) disable iff (!rstn)
      s_cap_pkt(is708, ACL_FILT_608) |=> route_valid && route.dest == ACL_DEST_DROP;
  endproperty
  a_608_only: assert property (p_608_only) // [R7]
    else $error("708 packet passed 608-only filter");
  property p_ttx_only;
    @(posedge ref_clk) disable iff (!rstn)
      pkt_valid && cap_en && filt == ACL_FILT_TTX && (is708 || is608)
      |=> route.dest == ACL_DEST_DROP;
  endproperty
  a_ttx_only: assert property (p_ttx_only) // [R8]
    else $error("caption packet passed teletext filter");
  property p_manual_fmt;
    @(posedge ref_clk) disable iff (!rstn)
      fmt_en && fsrc == ACL_FSRC_MANUAL && frame_start |=> fmt_valid && fmt_value == $past(fval);
  endproperty
  a_manual_fmt: assert property (p_manual_fmt) // [R12]
    else $error("manual descriptor not inserted");
  property p_fmt_off;
    @(posedge ref_clk) disable iff (!rstn)
      !fmt_en ##1 !$past(fmt_en) |-> !fmt_valid;
  endproperty
  a_fmt_off: assert property (p_fmt_off) // [R14]
    else $error("descriptor emitted while disabled");
  property p_line_cap;
    @(posedge ref_clk) disable iff (!rstn)
      line_cap |=> cap_line_valid && cap_line.line == `ACL_LINE_CAP;
  endproperty
  a_line_cap: assert property (p_line_cap) // [R3]
    else $error("line-21 caption word lost");
  property p_expand;
    @(posedge ref_clk) disable iff (!rstn)
      s_pair_write |=> pair_r[$past(pair_idx)][8] == ^$past(pwdata[7:0]) &&
                       pair_r[$past(pair_idx)][9] == ~^$past(pwdata[7:0]);
  endproperty
  a_expand: assert property (p_expand) // [R23]
    else $error("identifier widening wrong");
  property p_offs_range;
    @(posedge ref_clk) disable iff (!rstn)
      route_valid |-> $signed(route.frame_offset) >= -4'sd5 &&
                      $signed(route.frame_offset) <= 4'sd5;
  endproperty
  a_offs_range: assert property (p_offs_range) // [R19]
    else $error("frame offset out of range");
  property p_trig;
    @(posedge ref_clk) disable iff (!rstn)
      pkt_valid && is_trig && trig_en |=> route.dest == ACL_DEST_TRIG;
  endproperty
  a_trig: assert property (p_trig) // [R15]
    else $error("trigger packet not routed");
endmodule : acl_classifier

// file: sim/acl_anc_src.sv
// Model of the ancillary extractor feeding packet headers.
// Assumes the classifier samples headers on ref_clk.
`timescale 1ns/1ps
module acl_anc_src
  import acl_pkg::*;
(
  input  wire logic            ref_clk,   // System clock
  output logic                 pkt_valid, // Header strobe
  output acl_pkg::acl_pkt_type pkt        // Header
);
  initial begin
    pkt_valid = 1'b0;
    pkt = '0;
  end
  // HANC set on every header; VANC packets are never sent
  task automatic send(input logic [9:0] did, input logic [9:0] sdid);
    @(posedge ref_clk);
    pkt_valid <= 1'b1;
    pkt <= '{did, sdid, 1'b1, 16'h0040, 8'h00};
    @(posedge ref_clk);
    pkt_valid <= 1'b0;
    pkt <= ~pkt;  // Stale header must not look valid
  endtask : send
endmodule : acl_anc_src

// file: sim/acl_classifier_tb.sv
// Self-checking bench of the classifier over APB and packet ports.
// Assumes acl_anc_src as packet source; bench drives SD and VBI inputs.
`timescale 1ns/1ps
module acl_classifier_tb;
  import acl_pkg::*;
  logic          ref_clk, rstn, psel, penable, pwrite, frame_start;
  logic          pready, pslverr, route_valid, fmt_valid, pkt_valid, err;
  logic          is_sd, is_pal, vbi_valid, cap_line_valid;
  acl_vbi_type   vbi, cap_line;
  logic [11:0]   paddr, page;
  logic [31:0]   pwdata, prdata, rd;
  logic [23:0]   lang;
  logic [3:0]    fmt_value;
  acl_route_type route;
  acl_pkt_type   pkt;
  integer        miscompares, checks, cycles;
  acl_anc_src src_i (.ref_clk(ref_clk), .pkt_valid(pkt_valid), .pkt(pkt));
  acl_classifier acl_classifier_i (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .is_sd(is_sd), .is_pal(is_pal),
    .frame_start(frame_start), .pkt_valid(pkt_valid), .pkt(pkt), .vbi_valid(vbi_valid),
    .vbi(vbi), .route_valid(route_valid), .route(route), .cap_line_valid(cap_line_valid),
    .cap_line(cap_line), .fmt_valid(fmt_valid), .fmt_value(fmt_value),
    .teletext_caption_language(lang), .teletext_caption_page(page));
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pkt_chk(input logic [31:0] c, input logic [9:0] d, s, input logic [2:0] x);
    apb(1'b1, 12'h000, c);
    src_i.send(d, s);
    #1;
    check("route_valid", 32'h1, {31'h0, route_valid});
    check("dest", {29'h0, x}, {29'h0, route.dest});
  endtask : pkt_chk
  task automatic frame(input logic [31:0] c);
    apb(1'b1, 12'h000, c);
    @(posedge ref_clk);
    frame_start <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    #1;
  endtask : frame
  // Mode m: bit 1 SD input, bit 0 PAL
  task automatic vbi_line(input logic [31:0] c, input logic [1:0] m, input logic [10:0] n,
                          input logic [15:0] w);
    apb(1'b1, 12'h000, c);
    @(posedge ref_clk);
    is_sd <= m[1];
    is_pal <= m[0];
    vbi_valid <= 1'b1;
    vbi <= '{n, 1'b1, w};
    @(posedge ref_clk);
    vbi_valid <= 1'b0;
    #1;
  endtask : vbi_line
  task automatic print_verdict;
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rstn, psel, penable, pwrite, frame_start, paddr, pwdata, is_sd, is_pal, vbi_valid, vbi} = '0;
    {miscompares, checks, cycles} = '0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    check("lang", 32'h00656E67, rd);
    check("page", 32'h321, {20'h0, page});
    apb(1'b0, 12'h010, 32'h0);
    check("pair0", 32'h02000200, rd);
    apb(1'b0, 12'h040, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 12'h008, 32'h00667261);
    @(posedge ref_clk);
    #1;
    check("lang out", 32'h00667261, {8'h0, lang});
    apb(1'b1, 12'h010, 32'h80600060);
    apb(1'b0, 12'h010, 32'h0);
    check("pair0 wide", 32'h82600260, rd);
    apb(1'b1, 12'h014, 32'h81070241);
    pkt_chk(32'h01, 10'h161, 10'h101, 3'h1);
    pkt_chk(32'h01, 10'h161, 10'h102, 3'h2);
    pkt_chk(32'h41, 10'h161, 10'h102, 3'h0);
    pkt_chk(32'h41, 10'h161, 10'h101, 3'h1);
    pkt_chk(32'h81, 10'h161, 10'h101, 3'h0);
    pkt_chk(32'hC1, 10'h143, 10'h102, 3'h3);
    pkt_chk(32'hC1, 10'h161, 10'h102, 3'h0);
    pkt_chk(32'h00, 10'h161, 10'h101, 3'h0);
    pkt_chk(32'h04, 10'h241, 10'h107, 3'h4);
    pkt_chk(32'h08, 10'h241, 10'h20C, 3'h5);
    pkt_chk(32'h70010, 10'h260, 10'h260, 3'h6);
    check("offset", 32'h5, {28'h0, route.frame_offset});
    pkt_chk(32'h10, 10'h241, 10'h107, 3'h0);
    apb(1'b1, 12'h010, 32'h00600060);
    pkt_chk(32'h10, 10'h260, 10'h260, 3'h0);
    frame(32'h2602);
    check("fmt_valid", 32'h1, {31'h0, fmt_valid});
    check("fmt_value", 32'h9, {28'h0, fmt_value});
    frame(32'h1602);
    check("fmt illegal", 32'h9, {28'h0, fmt_value});
    frame(32'h2600);
    check("fmt off", 32'h0, {31'h0, fmt_valid});
    vbi_line(32'h21, 2'h2, 11'h015, 16'h1234);
    check("cap_line_valid", 32'h1, {31'h0, cap_line_valid});
    check("cap_line", 32'h1234, {16'h0, cap_line.data});
    pkt_chk(32'h21, 10'h161, 10'h102, 3'h0);
    vbi_line(32'h102, 2'h2, 11'h014, 16'h0008);
    check("wss ntsc", 32'h1, {31'h0, fmt_valid});
    vbi_line(32'h102, 2'h3, 11'h014, 16'h0008);
    check("wss pal line 20", 32'h0, {31'h0, fmt_valid});
    vbi_line(32'h102, 2'h3, 11'h017, 16'h0008);
    check("wss pal", 32'h1, {31'h0, fmt_valid});
    vbi_line(32'h102, 2'h0, 11'h014, 16'h0008);
    check("wss on hd", 32'h0, {31'h0, fmt_valid});
    pkt_chk(32'h102, 10'h241, 10'h205, 3'h0);
    check("vanc fallback", 32'h1, {31'h0, fmt_valid});
    check("vanc code", 32'h0, {28'h0, fmt_value});
    pkt_chk(32'h2202, 10'h241, 10'h205, 3'h0);
    check("manual ignores vanc", 32'h0, {31'h0, fmt_valid});
    apb(1'b1, 12'h010, 32'h80600060);
    apb(1'b1, 12'h004, 32'h1);
    pkt_chk(32'h10, 10'h260, 10'h260, 3'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("drops", 32'h1, {16'h0, rd[31:16]});
    print_verdict();
  end
endmodule : acl_classifier_tb
